// *** include/lvdsd_cfg.svh ***
// Constants for the display-link deserializer: widths, lane layout, timing counts.
// Assumes a 50 MHz system clock; the idle cycle count below is derived from that rate.
`ifndef LVDSD_CFG_SVH
`define LVDSD_CFG_SVH

`define LVDSD_WORD_W 27
`define LVDSD_LANES 4
`define LVDSD_SHIFT_W 14
`define LVDSD_BITS_4 7
`define LVDSD_BITS_2 14
`define LVDSD_SLOT_W 7
`define LVDSD_HI_W 6
`define LVDSD_CNT_W 8
`define LVDSD_ACC_W 10
`define LVDSD_CLK_MHZ 50
`define LVDSD_IDLE_NS 1000
`define LVDSD_IDLE_CYC ((`LVDSD_IDLE_NS * `LVDSD_CLK_MHZ) / 1000)
`define LVDSD_LOCK_PERIODS 4
`define LVDSD_FIFO_DEPTH 8
`define LVDSD_CNT_RST 8'h00
`define LVDSD_PER_RST 8'hff
`define LVDSD_SY_CLK 0
`define LVDSD_SY_LANE 1
`define LVDSD_SY_MODE 5
`define LVDSD_SY_PDN 6
`define LVDSD_SY_ORD 7
`define LVDSD_SY_POL 8
`define LVDSD_SY_HOLD 9
`define LVDSD_SY_W 10

`endif

// *** include/lvdsd_pkg.sv ***
// Types shared by the deserializer modules.
// Assumes nothing of its surroundings.
package lvdsd_pkg;

   typedef enum logic [3:0] {
      ST_SHUTDOWN = 4'h1,
      ST_STANDBY = 4'h2,
      ST_LOCKING = 4'h4,
      ST_ACTIVE = 4'h8
   } lvdsd_state_t;

endpackage : lvdsd_pkg

// *** rtl/lvdsd_lane.sv ***
// One serial-to-parallel lane shifter, first bit ends up most significant.
// Assumes shift pulses come from the sampling-rate divider in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "lvdsd_cfg.svh"

module lvdsd_lane #(
   parameter int unsigned WIDTH = `LVDSD_SHIFT_W // Bits held per lane
) (
   input wire logic clk_sys_i, // System clock
   input wire logic resetn_i, // Async reset, active low
   input wire logic shift_i, // Sample pulse
   input wire logic bit_i, // Synchronised lane level
   output logic [WIDTH-1:0] bits_o // Last WIDTH samples
);

   logic [WIDTH-1:0] shift_reg;
   logic [WIDTH-1:0] shift_next;

   always_comb begin
      shift_next = shift_reg;
      if (shift_i) begin
         shift_next = {shift_reg[WIDTH-2:0], bit_i};
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         shift_reg <= '0;
      end else begin
         shift_reg <= shift_next;
      end
   end

   assign bits_o = shift_reg;

endmodule : lvdsd_lane
`default_nettype wire

// *** rtl/lvdsd_fifo.sv ***
// Word buffer between capture and the parallel output, valid/ready both sides.
// Assumes DEPTH is a power of two; clear_i empties it at once.
`timescale 1ns/1ps
`default_nettype none
`include "lvdsd_cfg.svh"

module lvdsd_fifo #(
   parameter int unsigned WIDTH = `LVDSD_WORD_W, // Word width
   parameter int unsigned DEPTH = `LVDSD_FIFO_DEPTH // Words held
) (
   input wire logic clk_sys_i, // System clock
   input wire logic resetn_i, // Async reset, active low
   input wire logic clear_i, // Drop all content
   input wire logic in_valid_i, // Write request
   output logic in_ready_o, // Not full
   input wire logic [WIDTH-1:0] in_data_i, // Write word
   output logic out_valid_o, // Not empty
   input wire logic out_ready_i, // Read accept
   output logic [WIDTH-1:0] out_data_o // Head word
);

   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_reg;
   logic [AW:0] wr_next;
   logic [AW:0] rd_reg;
   logic [AW:0] rd_next;
   logic push;
   logic pop;

   // Extra pointer bit tells full from empty
   assign in_ready_o = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
   assign out_valid_o = (wr_reg != rd_reg);
   assign out_data_o = mem[rd_reg[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;

   always_comb begin
      wr_next = wr_reg + {{AW{1'b0}}, push};
      rd_next = rd_reg + {{AW{1'b0}}, pop};
      if (clear_i) begin
         wr_next = '0;
         rd_next = '0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_reg <= '0;
         rd_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
      end
   end

   // Storage needs no reset; empty pointers hide it
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_reg[AW-1:0]] <= in_data_i;
      end
   end

endmodule : lvdsd_fifo
`default_nettype wire

// *** rtl/lvdsd_top.sv ***
// Display-link deserializer: link clock and four serial lanes in, 27-bit parallel bus out.
// Assumes all link and strap pins are asynchronous to clk_sys_i; the link clock
// period must span at least one system cycle per sampled bit.
// Function
// - Select low: four lanes, seven bits each
// - Four-lane slot layout, reserved slot first
// - Select high: two lanes, fourteen bits each
// - Lane layout follows select input only
// - Reserved slot never reaches outputs
// - Bits pass by position only
// - Order input high mirrors output bus
// - Idle link clock enters standby automatically
// - Power-down input low forces shutdown
// - Standby and shutdown drive outputs low
// - Sampling rate is link clock times bits
// - 27 bits per period, selectable clock edge
`timescale 1ns/1ps
`default_nettype none
`include "lvdsd_cfg.svh"

module lvdsd_top #(
   parameter int unsigned IDLE_CYC = `LVDSD_IDLE_CYC, // Cycles without link edge before standby
   parameter int unsigned LOCK_PERIODS = `LVDSD_LOCK_PERIODS, // Steady periods needed for lock
   parameter int unsigned FIFO_DEPTH = `LVDSD_FIFO_DEPTH // Buffered words
) (
   input wire logic clk_sys_i, // 50 MHz system clock
   input wire logic resetn_i, // Async reset, active low
   input wire logic link_clk_i, // Link clock lane level
   input wire logic [`LVDSD_LANES-1:0] lane_data_i, // Serial data lanes
   input wire logic lane_count_select_i, // Low four lanes, high two lanes
   input wire logic power_down_n_i, // Shutdown request, active low
   input wire logic output_order_i, // High mirrors the bus
   input wire logic output_edge_polarity_i, // High: data valid on rising edge
   input wire logic pixel_hold_i, // Panel stall, freezes output
   output logic [`LVDSD_WORD_W-1:0] pixel_data_o, // Parallel pixel bus
   output logic forwarded_pixel_clock_o, // Forwarded pixel clock
   output logic standby_o, // Link idle
   output logic shutdown_o, // Powered down
   output logic locked_o, // Sampling locked, bus live
   output logic word_dropped_o // Word lost to full buffer, pulse
);

   localparam logic [`LVDSD_CNT_W-1:0] IDLE_W = `LVDSD_CNT_W'(IDLE_CYC);
   localparam logic [`LVDSD_CNT_W-1:0] LOCK_W = `LVDSD_CNT_W'(LOCK_PERIODS);
   localparam logic [3:0] N4 = 4'(`LVDSD_BITS_4);
   localparam logic [3:0] N2 = 4'(`LVDSD_BITS_2);
   localparam int unsigned SW = `LVDSD_SLOT_W;
   localparam int unsigned HW = `LVDSD_HI_W;

   // Pin synchronisers
   logic [`LVDSD_SY_W-1:0] pins;
   logic [`LVDSD_SY_W-1:0] sync1_reg;
   logic [`LVDSD_SY_W-1:0] sync2_reg;

   assign pins = {pixel_hold_i, output_edge_polarity_i, output_order_i, power_down_n_i,
                  lane_count_select_i, lane_data_i, link_clk_i};

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
      end
   end

   logic lclk_s;
   logic [`LVDSD_LANES-1:0] lanes_s;
   logic mode_s;
   logic pdn_s;
   logic ord_s;
   logic pol_s;
   logic hold_s;

   assign lclk_s = sync2_reg[`LVDSD_SY_CLK];
   assign lanes_s = sync2_reg[`LVDSD_SY_LANE +: `LVDSD_LANES];
   assign mode_s = sync2_reg[`LVDSD_SY_MODE];
   assign pdn_s = sync2_reg[`LVDSD_SY_PDN];
   assign ord_s = sync2_reg[`LVDSD_SY_ORD];
   assign pol_s = sync2_reg[`LVDSD_SY_POL];
   assign hold_s = sync2_reg[`LVDSD_SY_HOLD];

   // Link tracking, sampling and mode state
   lvdsd_pkg::lvdsd_state_t st_reg;
   lvdsd_pkg::lvdsd_state_t st_next;
   logic lclk_prev_reg;
   logic [`LVDSD_CNT_W-1:0] cnt_reg;
   logic [`LVDSD_CNT_W-1:0] cnt_next;
   logic [`LVDSD_CNT_W-1:0] period_reg;
   logic [`LVDSD_CNT_W-1:0] period_next;
   logic [`LVDSD_CNT_W-1:0] stable_reg;
   logic [`LVDSD_CNT_W-1:0] stable_next;
   logic mode_reg;
   logic [`LVDSD_ACC_W-1:0] acc_reg;
   logic [`LVDSD_ACC_W-1:0] acc_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;

   logic edge_det;
   logic idle_hit;
   logic mode_chg;
   logic per_ok;
   logic bit_en;
   logic capture;
   logic [3:0] n_bits;
   logic [`LVDSD_CNT_W-1:0] per_diff;
   logic [`LVDSD_ACC_W-1:0] acc_base;
   logic [`LVDSD_ACC_W-1:0] acc_sum;
   logic [`LVDSD_ACC_W-1:0] two_p;
   logic [3:0] bit_cnt_base;

   assign edge_det = lclk_s && !lclk_prev_reg;
   assign mode_chg = (mode_s != mode_reg);
   assign idle_hit = !edge_det && (cnt_reg >= IDLE_W);
   assign n_bits = mode_reg ? N2 : N4;

   always_comb begin
      per_diff = (cnt_reg > period_reg) ? (cnt_reg - period_reg) : (period_reg - cnt_reg);
      // Tolerate one cycle of edge jitter from the synchroniser
      per_ok = (per_diff <= `LVDSD_CNT_W'(1)) && (cnt_reg >= {4'h0, n_bits});
      cnt_next = edge_det ? `LVDSD_CNT_W'(1) : ((cnt_reg == '1) ? cnt_reg : cnt_reg + `LVDSD_CNT_W'(1));
      period_next = edge_det ? cnt_reg : period_reg;
      // Rate multiplier: n pulses per period
      two_p = {1'b0, period_reg, 1'b0};
      acc_base = edge_det ? {6'h00, n_bits} : acc_reg;
      acc_sum = acc_base + {5'h00, n_bits, 1'b0};
      bit_cnt_base = edge_det ? 4'h0 : bit_cnt_reg;
      bit_en = (acc_sum >= two_p) && (bit_cnt_base < n_bits);
      acc_next = (acc_sum >= two_p) ? (acc_sum - two_p) : acc_sum;
      bit_cnt_next = bit_cnt_base + {3'h0, bit_en};
   end

   assign capture = edge_det && (st_reg == lvdsd_pkg::ST_ACTIVE) && (bit_cnt_reg == n_bits) && !mode_chg;

   always_comb begin
      st_next = st_reg;
      stable_next = stable_reg;
      if (!pdn_s) begin
         st_next = lvdsd_pkg::ST_SHUTDOWN;
         stable_next = '0;
      end else begin
         case (st_reg)
            lvdsd_pkg::ST_SHUTDOWN: begin
               st_next = lvdsd_pkg::ST_STANDBY;
            end
            lvdsd_pkg::ST_STANDBY: begin
               if (edge_det) begin
                  st_next = lvdsd_pkg::ST_LOCKING;
                  stable_next = '0;
               end
            end
            lvdsd_pkg::ST_LOCKING: begin
               if (idle_hit) begin
                  st_next = lvdsd_pkg::ST_STANDBY;
               end else if (mode_chg) begin
                  stable_next = '0;
               end else if (edge_det) begin
                  if (per_ok) begin
                     stable_next = stable_reg + `LVDSD_CNT_W'(1);
                     if (stable_reg >= LOCK_W - `LVDSD_CNT_W'(1)) begin
                        st_next = lvdsd_pkg::ST_ACTIVE;
                     end
                  end else begin
                     stable_next = '0;
                  end
               end
            end
            lvdsd_pkg::ST_ACTIVE: begin
               if (idle_hit) begin
                  st_next = lvdsd_pkg::ST_STANDBY;
                  stable_next = '0;
               end else if (mode_chg || (edge_det && !per_ok)) begin
                  st_next = lvdsd_pkg::ST_LOCKING;
                  stable_next = '0;
               end
            end
            default: begin
               st_next = lvdsd_pkg::ST_SHUTDOWN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_reg <= lvdsd_pkg::ST_SHUTDOWN;
         lclk_prev_reg <= 1'b0;
         cnt_reg <= `LVDSD_CNT_RST;
         period_reg <= `LVDSD_PER_RST;
         stable_reg <= '0;
         mode_reg <= 1'b0;
         acc_reg <= '0;
         bit_cnt_reg <= '0;
      end else begin
         st_reg <= st_next;
         lclk_prev_reg <= lclk_s;
         cnt_reg <= cnt_next;
         period_reg <= period_next;
         stable_reg <= stable_next;
         mode_reg <= mode_s;
         acc_reg <= acc_next;
         bit_cnt_reg <= bit_cnt_next;
      end
   end

   // Lane shifters
   logic [`LVDSD_SHIFT_W-1:0] lane_q [`LVDSD_LANES];

   for (genvar g = 0; g < `LVDSD_LANES; g++) begin : g_lane
      lvdsd_lane #(
         .WIDTH(`LVDSD_SHIFT_W)
      ) u_lane (
         .clk_sys_i(clk_sys_i),
         .resetn_i(resetn_i),
         .shift_i(bit_en),
         .bit_i(lanes_s[g]),
         .bits_o(lane_q[g])
      );
   end

   // Word assembly, positional only
   logic [`LVDSD_WORD_W-1:0] word;

   always_comb begin
      if (!mode_reg) begin
         // Reserved bit of lane three dropped
         word = {lane_q[3][HW-1:0], lane_q[2][SW-1:0], lane_q[1][SW-1:0], lane_q[0][SW-1:0]};
      end else begin
         // Reserved bit of second slot dropped
         word = {lane_q[1][HW-1:0], lane_q[1][2*SW-1:SW], lane_q[0][SW-1:0], lane_q[0][2*SW-1:SW]};
      end
   end

   // Buffer toward the panel
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [`LVDSD_WORD_W-1:0] fifo_out;
   logic pop;

   // No pop on the edge that leaves active; the bus is forced low then
   assign pop = edge_det && (st_reg == lvdsd_pkg::ST_ACTIVE) && (st_next == lvdsd_pkg::ST_ACTIVE)
                && fifo_out_valid && !hold_s;

   lvdsd_fifo #(
      .WIDTH(`LVDSD_WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .clear_i(st_reg != lvdsd_pkg::ST_ACTIVE),
      .in_valid_i(capture),
      .in_ready_o(fifo_in_ready),
      .in_data_i(word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_out)
   );

   // Output stage
   logic [`LVDSD_WORD_W-1:0] data_reg;
   logic [`LVDSD_WORD_W-1:0] data_next;
   logic fwd_reg;
   logic fwd_next;
   logic drop_reg;
   logic drop_next;
   logic [`LVDSD_WORD_W-1:0] mirrored;

   always_comb begin
      for (int i = 0; i < `LVDSD_WORD_W; i++) begin
         mirrored[i] = fifo_out[`LVDSD_WORD_W-1-i];
      end
      data_next = data_reg;
      fwd_next = 1'b0;
      drop_next = capture && !fifo_in_ready;
      // Low outside active operation
      // Follows the next state, so the bus drops together with locked_o
      if (st_next != lvdsd_pkg::ST_ACTIVE) begin
         data_next = '0;
      end else begin
         if (pop) begin
            data_next = ord_s ? mirrored : fifo_out;
         end
         fwd_next = pol_s ^ lclk_s;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_reg <= '0;
         fwd_reg <= 1'b0;
         drop_reg <= 1'b0;
      end else begin
         data_reg <= data_next;
         fwd_reg <= fwd_next;
         drop_reg <= drop_next;
      end
   end

   assign pixel_data_o = data_reg;
   assign forwarded_pixel_clock_o = fwd_reg;
   assign word_dropped_o = drop_reg;
   assign standby_o = (st_reg == lvdsd_pkg::ST_STANDBY);
   assign shutdown_o = (st_reg == lvdsd_pkg::ST_SHUTDOWN);
   assign locked_o = (st_reg == lvdsd_pkg::ST_ACTIVE);

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   property p_four_lane;
      edge_det && (st_reg == lvdsd_pkg::ST_ACTIVE) && !mode_reg && !mode_chg && (cnt_reg == period_reg)
         |-> bit_cnt_reg == 4'h7;
   endproperty
   a_four_lane: assert property (p_four_lane) else $error("Four-lane period sample count wrong");

   property p_slot_map;
      capture && !mode_reg |-> (word[26:21] == lane_q[3][5:0]) && (word[6:0] == lane_q[0][6:0]);
   endproperty
   a_slot_map: assert property (p_slot_map) else $error("Four-lane slot placement wrong");

   property p_two_lane;
      edge_det && (st_reg == lvdsd_pkg::ST_ACTIVE) && mode_reg && !mode_chg && (cnt_reg == period_reg)
         |-> bit_cnt_reg == 4'he;
   endproperty
   a_two_lane: assert property (p_two_lane) else $error("Two-lane period sample count wrong");

   property p_mode_relock;
      (st_reg == lvdsd_pkg::ST_ACTIVE) && mode_chg && pdn_s && !idle_hit |=> st_reg == lvdsd_pkg::ST_LOCKING;
   endproperty
   a_mode_relock: assert property (p_mode_relock) else $error("Select change did not force relock");

   property p_mirror;
      pop && ord_s |=> (pixel_data_o[0] == $past(fifo_out[26])) && (pixel_data_o[26] == $past(fifo_out[0]));
   endproperty
   a_mirror: assert property (p_mirror) else $error("Mirrored bus order wrong");

   property p_idle_standby;
      idle_hit && pdn_s && (st_reg != lvdsd_pkg::ST_SHUTDOWN) |=> standby_o;
   endproperty
   a_idle_standby: assert property (p_idle_standby) else $error("Idle link did not enter standby");

   property p_shutdown;
      !pdn_s |=> shutdown_o ##1 (shutdown_o || !$past(pdn_s, 1) || standby_o);
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("Power-down input did not shut down");

   property p_low_power_out;
      standby_o || shutdown_o |-> (pixel_data_o == '0) && !forwarded_pixel_clock_o;
   endproperty
   a_low_power_out: assert property (p_low_power_out) else $error("Outputs not low in low power");

   property p_fwd_edge;
      locked_o |-> forwarded_pixel_clock_o == ($past(pol_s) ^ $past(lclk_s));
   endproperty
   a_fwd_edge: assert property (p_fwd_edge) else $error("Forwarded clock phase wrong");

   property p_lock_hold;
      $rose(locked_o) |-> ($past(stable_reg) == LOCK_W - `LVDSD_CNT_W'(1)) && (pixel_data_o == '0);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("Bus released before lock");

   c_active: cover property ($rose(locked_o));
   c_two_lane: cover property (capture && mode_reg);
   c_drop: cover property (capture && !fifo_in_ready);
   c_sleep: cover property (locked_o ##1 standby_o);

endmodule : lvdsd_top
`default_nettype wire

// *** sim/lvdsd_tx_model.sv ***
// Behavioural serial transmitter: link clock plus four data lanes.
// Assumes the bench changes word_i and noise_i only at link rising edges.
`timescale 1ns/1ps
`default_nettype none

module lvdsd_tx_model #(
   parameter real PER4 = 160.0, // Link period, four-lane, ns
   parameter real PER2 = 320.0 // Link period, two-lane, ns
) (
   input wire logic run_i, // Send frames
   input wire logic two_lane_i, // Two-lane layout
   input wire logic [26:0] word_i, // Word of next frame
   input wire logic [31:0] noise_i, // Filler and reserved bit
   output logic link_clk_o, // Link clock lane
   output logic [3:0] lane_o // Data lanes
);
   logic [13:0] s0, s1, s2, s3;
   int n;
   real per;

   initial begin
      link_clk_o = 1'b0;
      lane_o = 4'h0;
      // Off the bench's drive edges
      #3.0;
      forever begin
         if (!run_i) begin
            // Idle clock stands still; data never holds a stale level
            link_clk_o = 1'b0;
            lane_o = ~lane_o;
            #20.0;
         end else begin
            n = two_lane_i ? 14 : 7;
            per = two_lane_i ? PER2 : PER4;
            if (two_lane_i) begin
               s0 = {word_i[6:0], word_i[13:7]};
               s1 = {word_i[20:14], noise_i[31], word_i[26:21]};
               s2 = noise_i[13:0];
               s3 = noise_i[27:14];
            end else begin
               s0 = {7'h00, word_i[6:0]};
               s1 = {7'h00, word_i[13:7]};
               s2 = {7'h00, word_i[20:14]};
               s3 = {7'h00, noise_i[31], word_i[26:21]};
            end
            // n evenly spaced bits per period, first bit MSB
            for (int i = 0; i < n; i++) begin
               link_clk_o = (i < (n + 1) / 2) ? 1'b1 : 1'b0;
               lane_o = {s3[n-1-i], s2[n-1-i], s1[n-1-i], s0[n-1-i]};
               #(per / n);
            end
         end
      end
   end
endmodule : lvdsd_tx_model

`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the deserializer top: transmitter model, word queue, output monitor.
// Assumes the transmitter model file and the include folder on the search path.
`timescale 1ns/1ps
`default_nettype none
`include "lvdsd_cfg.svh"

module testbench;
   localparam int IDLE = 30;
   logic clk_sys_i, resetn_i, run, sel, pdn_n, order, pol, hold;
   logic link_clk, fwd, stby, shdn, lock, drop;
   logic [3:0] lanes;
   logic [26:0] word, data, last;
   logic [31:0] noise, rng;
   logic [26:0] q[$];
   int n_mismatch, n_checks, n_words, n_drop, drop_pend, hold_cnt;
   bit synced;

   lvdsd_tx_model i_tx (.run_i(run), .two_lane_i(sel), .word_i(word), .noise_i(noise),
      .link_clk_o(link_clk), .lane_o(lanes));

   lvdsd_top #(.IDLE_CYC(IDLE), .LOCK_PERIODS(2), .FIFO_DEPTH(8)) i_dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link_clk_i(link_clk), .lane_data_i(lanes),
      .lane_count_select_i(sel), .power_down_n_i(pdn_n), .output_order_i(order),
      .output_edge_polarity_i(pol), .pixel_hold_i(hold), .pixel_data_o(data),
      .forwarded_pixel_clock_o(fwd), .standby_o(stby), .shutdown_o(shdn), .locked_o(lock),
      .word_dropped_o(drop));

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs

   function automatic logic [26:0] mir(input logic [26:0] w);
      return order ? {<<{w}} : w;
   endfunction : mir

   task automatic close_out();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wait_lock();
      int k;
      repeat (10) @(negedge clk_sys_i);
      for (k = 0; k < 3000; k++) begin
         @(negedge clk_sys_i);
         if (lock === 1'b1) break;
      end
      if (k == 3000) begin
         n_mismatch++;
         $display("Error %0t: lock not reached", $time);
         close_out();
      end
   endtask : wait_lock

   task automatic seg(input int cyc);
      int base;
      base = n_words;
      repeat (cyc) @(negedge clk_sys_i);
      check({31'h0, (n_words - base) >= cyc / 20}, 32'h1);
   endtask : seg

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   // Next frame's word and filler, queued as the frame starts
   always @(posedge link_clk) begin
      if (run) begin
         q.push_back(word);
         rng = xs(rng);
         word <= rng[26:0];
         rng = xs(rng);
         noise <= rng;
      end
   end

   always @(negedge clk_sys_i) begin
      if (resetn_i) begin
         check({31'h0, lock & (stby | shdn)}, 32'h0);
         if (lock !== 1'b1) begin
            check({5'h00, data}, 32'h0);
            check({31'h0, fwd}, 32'h0);
            synced = 0;
            drop_pend = 0;
            while (q.size() > 4) void'(q.pop_front());
         end else if (data !== last) begin
            n_words++;
            check({31'h0, fwd}, {31'h0, ~pol});
            if (hold_cnt > 6) check({5'h00, data}, {5'h00, last});
            // Skip only words the design reported lost, once in step
            for (int k = 0; k < 64 && q.size() > 0; k++) begin
               if (mir(q[0]) === data) break;
               if (synced && drop_pend == 0) break;
               if (synced) drop_pend--;
               void'(q.pop_front());
            end
            check({5'h00, data}, q.size() > 0 ? {5'h00, mir(q[0])} : 32'h0);
            if (q.size() > 0) void'(q.pop_front());
            synced = 1;
         end
         if (drop === 1'b1) begin
            n_drop++;
            drop_pend++;
         end
         hold_cnt = hold ? hold_cnt + 1 : 0;
         last = data;
      end
   end

   initial begin
      repeat (100000) @(posedge clk_sys_i);
      n_mismatch++;
      $display("Error %0t: run timed out", $time);
      close_out();
   end

   initial begin
      resetn_i = 1'b0;
      {run, sel, order, pol, hold} = 5'h00;
      pdn_n = 1'b1;
      {n_mismatch, n_checks, n_words, n_drop, drop_pend, hold_cnt} = '0;
      synced = 0;
      last = 27'h0000000;
      rng = xs(32'h000083cc);
      word = rng[26:0];
      rng = xs(rng);
      noise = rng;
      repeat (20) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      run = 1'b1;
      wait_lock();
      seg(240);
      // Link goes quiet, then resumes
      run = 1'b0;
      repeat (IDLE + 20) @(negedge clk_sys_i);
      check({31'h0, stby}, 32'h1);
      check({31'h0, lock}, 32'h0);
      run = 1'b1;
      wait_lock();
      seg(160);
      // Panel stall fills the buffer past its depth
      hold = 1'b1;
      repeat (200) @(negedge clk_sys_i);
      hold = 1'b0;
      check({31'h0, n_drop > 0}, 32'h1);
      seg(240);
      // Power-down, then mirrored bus with inverted clock
      pdn_n = 1'b0;
      repeat (5) @(negedge clk_sys_i);
      check({31'h0, shdn}, 32'h1);
      repeat (40) @(negedge clk_sys_i);
      order = 1'b1;
      pol = 1'b1;
      pdn_n = 1'b1;
      wait_lock();
      seg(240);
      // Two-lane layout, then back to four lanes
      sel = 1'b1;
      wait_lock();
      seg(480);
      sel = 1'b0;
      wait_lock();
      seg(240);
      close_out();
   end
endmodule : testbench

`default_nettype wire
